/* hw/asf_pkg.sv */
package asf_pkg;
   // ************************************************************
   // section geometry
   // ************************************************************
   localparam int SECT_LEN = 20;
   localparam logic [5:0] SECT_LEN_CODE = 6'h14;
   localparam logic [1:0] MOD_DIAG_CODE = 2'h0;
   localparam logic ALARM_ID_CODE = 1'b1;
   localparam logic [6:0] TYPE_DIAG = 7'h01;
   localparam logic [6:0] TYPE_PROC = 7'h02;
   localparam logic [1:0] SPEC_PROC = 2'h0;
   localparam logic [1:0] SPEC_INCOMING = 2'h1;
   localparam logic [1:0] SPEC_OUTGOING = 2'h2;
   localparam logic [4:0] SEQ_FIRST = 5'h01;
   localparam logic [4:0] SEQ_LAST = 5'h1F;
   localparam logic [5:0] SLOT_MIN = 6'h01;
   localparam logic [5:0] SLOT_MAX = 6'h20;
   // ************************************************************
   // module class and channel type codes
   // ************************************************************
   localparam logic [3:0] CLASS_DIGITAL = 4'hF;
   localparam logic [3:0] CLASS_ANALOG = 4'h5;
   localparam logic [3:0] CLASS_FUNCTION_MODULE = 4'h8;
   localparam logic [3:0] CLASS_COMMUNICATION_PROCESSOR = 4'hC;
   localparam logic [7:0] CHT_DIG_IN = 8'h70;
   localparam logic [7:0] CHT_ANA_IN = 8'h71;
   localparam logic [7:0] CHT_DIG_OUT = 8'h72;
   localparam logic [7:0] CHT_ANA_OUT = 8'h73;
   localparam logic [7:0] CHT_ANA_INOUT = 8'h74;
   localparam logic [7:0] CHT_COUNTER = 8'h76;
   localparam logic [7:0] LOST_MASK = 8'h40;
   // ************************************************************
   // register map, byte addresses
   // ************************************************************
   localparam logic [5:0] REG_CTRL = 6'h00;
   localparam logic [5:0] REG_HDR = 6'h04;
   localparam logic [5:0] REG_REC0 = 6'h08;
   localparam logic [5:0] REG_CHAN = 6'h0C;
   localparam logic [5:0] REG_GRP_LO = 6'h10;
   localparam logic [5:0] REG_GRP_HI = 6'h14;
   localparam logic [5:0] REG_STAT = 6'h18;
   localparam logic [5:0] REG_PROC = 6'h1C;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int FIFO_W = 8;
   localparam int FIFO_D = 8;
endpackage : asf_pkg

/* hw/asf_fifo.sv */
`timescale 1ns/100ps
module asf_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0] cnt_r;
   logic push;
   logic pop;
   // ************************************************************
   // storage and pointers
   // ************************************************************
   assign in_ready = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data = mem[rp_r];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   // write side, no reset on storage to keep it a plain ram
   always_ff @(posedge aclk) begin
      if (push) begin
         mem[wp_r] <= in_data;
      end
   end
   // pointer and fill count
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
         end
         if (push && !pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (pop && !push) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule : asf_fifo

/* hw/asf_axil.sv */
`timescale 1ns/100ps
module asf_axil (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [5:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [5:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic wr_en,
   output logic [5:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [3:0] wr_strb,
   input wire logic wr_ok,
   output logic [5:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_ok
);
   logic aw_hold_r;
   logic w_hold_r;
   // ************************************************************
   // write channel: address and data taken in either order
   // ************************************************************
   assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
   assign s_axi_wready = !w_hold_r && !s_axi_bvalid;
   assign wr_en = aw_hold_r && w_hold_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         wr_addr <= '0;
         wr_data <= '0;
         wr_strb <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_r <= 1'b1;
            wr_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_r <= 1'b1;
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
         end
         if (wr_en) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? asf_pkg::RESP_OKAY : asf_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   // ************************************************************
   // read channel: one cycle to answer
   // ************************************************************
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_addr = s_axi_araddr;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= '0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_data;
         s_axi_rresp <= rd_ok ? asf_pkg::RESP_OKAY : asf_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule : asf_axil

/* hw/asf_framer.sv */
`timescale 1ns/100ps
// Summary of operation
// [R1] byte 0: length 010100 in bits 5..0, module diagnostic code in 7..6
// [R2] byte 1 bits 6..0: type 0000001 diagnostic, 0000010 process
// [R3] byte 1 bit 7 carries the interrupt identifying code
// [R4] byte 2 holds slot number 1 to 32 of the raising module
// [R5] byte 3 bits 1..0 specifier 00 process, 01 incoming, 10 outgoing; never 11
// [R6] byte 3 bit 2 is zero, bits 7..3 sequence number 1 to 32
// [R7] sequence advances per issued section, wraps to 1 after 32
// [R8] group 0 events are emitted even when group 0 diagnostics disabled
// [R9] byte 4: eight module error flags, bit 0 to bit 7
// [R10] byte 5 bits 3..0 module class code
// [R11] byte 5 bit 4 channel info, bit 5 user info, bits 7..6 zero
// [R12] byte 6: seven module status flags, bit 7 zero
// [R13] byte 7: only bit 6, process interrupt lost; others reserved zero
// [R14] byte 8: channel type code 70h to 76h
// [R15] byte 9 channel diagnostic length, byte 10 channel count
// [R16] bytes 12 to 19: one event byte per channel group 0 to 7
// [R17] process interrupt: bytes 4 to 7 carry module process alarm data
// [R18] one section per frame, placed last, at most twenty bytes
module asf_framer (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [5:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [5:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [7:0] sect_data,
   output logic sect_valid,
   output logic sect_last,
   input wire logic sect_ready
);
   typedef enum logic [1:0] {ASF_IDLE, ASF_FILL, ASF_DRAIN} asf_state_t;
   // ************************************************************
   // register file
   // ************************************************************
   logic wr_en;
   logic [5:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic wr_ok;
   logic [5:0] rd_addr;
   logic [31:0] rd_data;
   logic rd_ok;
   logic [31:0] hdr_r;
   logic [31:0] rec0_r;
   logic [31:0] chan_r;
   logic [31:0] grp_lo_r;
   logic [31:0] grp_hi_r;
   logic [31:0] proc_r;
   logic [7:0] grp_en_r;
   logic [4:0] seq_r;
   logic [7:0] issued_r;
   logic [7:0] dropped_r;
   logic bad_r;
   logic start;
   logic [31:0] wmask;
   asf_state_t state_r;
   logic [4:0] idx_r;
   logic [7:0] byte_nxt;
   logic fifo_in_ready;
   logic [7:0] fifo_out;
   logic fifo_out_valid;
   logic [4:0] fifo_cnt_r;
   logic is_diag;
   logic [1:0] spec;
   logic [5:0] slot;
   logic [7:0] grp_byte;
   logic [2:0] grp_sel;
   asf_axil u_axil (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .wr_ok(wr_ok),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_ok(rd_ok)
   );
   // byte lanes to bit mask
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wmask[i*8 +: 8] = {8{wr_strb[i]}};
      end
   end
   assign wr_ok = (wr_addr <= asf_pkg::REG_PROC) && (wr_addr[1:0] == 2'h0) && (wr_addr != asf_pkg::REG_STAT);
   assign rd_ok = (rd_addr <= asf_pkg::REG_PROC) && (rd_addr[1:0] == 2'h0);
   // a start request while busy is counted as dropped, one section per frame
   assign start = wr_en && (wr_addr == asf_pkg::REG_CTRL) && wr_strb[0] && wr_data[0];
   // ************************************************************
   // software-written fields
   // ************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hdr_r <= '0;
         rec0_r <= '0;
         chan_r <= '0;
         grp_lo_r <= '0;
         grp_hi_r <= '0;
         proc_r <= '0;
         grp_en_r <= '0;
      end else if (wr_en) begin
         case (wr_addr)
            asf_pkg::REG_CTRL: grp_en_r <= wr_strb[1] ? wr_data[15:8] : grp_en_r;
            asf_pkg::REG_HDR: hdr_r <= (hdr_r & ~wmask) | (wr_data & wmask);
            asf_pkg::REG_REC0: rec0_r <= (rec0_r & ~wmask) | (wr_data & wmask);
            asf_pkg::REG_CHAN: chan_r <= (chan_r & ~wmask) | (wr_data & wmask);
            asf_pkg::REG_GRP_LO: grp_lo_r <= (grp_lo_r & ~wmask) | (wr_data & wmask);
            asf_pkg::REG_GRP_HI: grp_hi_r <= (grp_hi_r & ~wmask) | (wr_data & wmask);
            asf_pkg::REG_PROC: proc_r <= (proc_r & ~wmask) | (wr_data & wmask);
            default: ;
         endcase
      end
   end
   // readback: status shows engine state, sequence and counters
   always_comb begin
      case (rd_addr)
         asf_pkg::REG_CTRL: rd_data = {16'h0000, grp_en_r, 7'h00, (state_r != ASF_IDLE)};
         asf_pkg::REG_HDR: rd_data = hdr_r;
         asf_pkg::REG_REC0: rd_data = rec0_r;
         asf_pkg::REG_CHAN: rd_data = chan_r;
         asf_pkg::REG_GRP_LO: rd_data = grp_lo_r;
         asf_pkg::REG_GRP_HI: rd_data = grp_hi_r;
         asf_pkg::REG_STAT: rd_data = {dropped_r, issued_r, 2'h0, bad_r, seq_r, 6'h00, state_r};
         asf_pkg::REG_PROC: rd_data = proc_r;
         default: rd_data = '0;
      endcase
   end
   // ************************************************************
   // byte assembly
   // ************************************************************
   assign is_diag = hdr_r[0];
   assign spec = is_diag ? (hdr_r[1] ? asf_pkg::SPEC_OUTGOING : asf_pkg::SPEC_INCOMING) : asf_pkg::SPEC_PROC; // R5
   assign slot = hdr_r[13:8];
   assign grp_sel = 3'(idx_r - 5'd12);
   // group 0 passes regardless of its enable; a module error may hide there
   always_comb begin
      grp_byte = grp_sel[2] ? grp_hi_r[grp_sel[1:0]*8 +: 8] : grp_lo_r[grp_sel[1:0]*8 +: 8];
      if (grp_sel != 3'h0 && !grp_en_r[grp_sel]) begin // R8
         grp_byte = 8'h00;
      end
   end
   always_comb begin
      case (idx_r)
         5'd0: byte_nxt = {asf_pkg::MOD_DIAG_CODE, asf_pkg::SECT_LEN_CODE}; // R1
         5'd1: byte_nxt = {asf_pkg::ALARM_ID_CODE, is_diag ? asf_pkg::TYPE_DIAG : asf_pkg::TYPE_PROC}; // R2 R3
         5'd2: byte_nxt = {2'b00, slot}; // R4
         5'd3: byte_nxt = {seq_r, 1'b0, spec}; // R6
         5'd4: byte_nxt = is_diag ? rec0_r[7:0] : proc_r[7:0]; // R9 R17
         5'd5: byte_nxt = is_diag ? {2'b00, rec0_r[13:12], rec0_r[11:8]} : proc_r[15:8]; // R10 R11
         5'd6: byte_nxt = is_diag ? {1'b0, rec0_r[22:16]} : proc_r[23:16]; // R12
         5'd7: byte_nxt = is_diag ? (rec0_r[31:24] & asf_pkg::LOST_MASK) : proc_r[31:24]; // R13
         5'd8: byte_nxt = chan_r[7:0]; // R14
         5'd9: byte_nxt = chan_r[15:8]; // R15
         5'd10: byte_nxt = chan_r[23:16]; // R15
         5'd11: byte_nxt = chan_r[31:24];
         default: byte_nxt = grp_byte; // R16
      endcase
   end
   // ************************************************************
   // section engine: twenty bytes into the fifo, then drain
   // ************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= ASF_IDLE;
         idx_r <= '0;
         bad_r <= 1'b0;
      end else begin
         case (state_r)
            ASF_IDLE: begin
               // slot outside 1..32 refuses the start rather than emit garbage
               if (start) begin
                  bad_r <= (slot < asf_pkg::SLOT_MIN) || (slot > asf_pkg::SLOT_MAX); // R4
                  if ((slot >= asf_pkg::SLOT_MIN) && (slot <= asf_pkg::SLOT_MAX)) begin
                     state_r <= ASF_FILL;
                     idx_r <= '0;
                  end
               end
            end
            ASF_FILL: begin
               if (fifo_in_ready) begin
                  idx_r <= idx_r + 5'd1;
                  if (idx_r == 5'(asf_pkg::SECT_LEN - 1)) begin // R18
                     state_r <= ASF_DRAIN;
                  end
               end
            end
            ASF_DRAIN: begin
               if (sect_valid && sect_ready && sect_last) begin
                  state_r <= ASF_IDLE;
               end
            end
            default: state_r <= ASF_IDLE;
         endcase
      end
   end
   // sequence number and counters
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         seq_r <= asf_pkg::SEQ_FIRST;
         issued_r <= '0;
         dropped_r <= '0;
      end else begin
         // wraps 32 -> 1; 32 is encoded as 0 in five bits
         if (state_r == ASF_DRAIN && sect_valid && sect_ready && sect_last) begin
            seq_r <= (seq_r == 5'h00) ? asf_pkg::SEQ_FIRST : ((seq_r == asf_pkg::SEQ_LAST) ? 5'h00 : seq_r + 5'd1); // R7
            issued_r <= issued_r + 8'd1;
         end
         if (start && state_r != ASF_IDLE) begin
            dropped_r <= dropped_r + 8'd1; // R18
         end
      end
   end
   asf_fifo #(
      .WIDTH(asf_pkg::FIFO_W),
      .DEPTH(asf_pkg::FIFO_D)
   ) u_fifo (
      .aclk(aclk),
      .aresetn(aresetn),
      .in_data(byte_nxt),
      .in_valid(state_r == ASF_FILL),
      .in_ready(fifo_in_ready),
      .out_data(fifo_out),
      .out_valid(fifo_out_valid),
      .out_ready(!sect_valid || sect_ready)
   );
   // ************************************************************
   // output register stage
   // ************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sect_valid <= 1'b0;
         sect_data <= '0;
         sect_last <= 1'b0;
         fifo_cnt_r <= '0;
      end else if (!sect_valid || sect_ready) begin
         sect_valid <= fifo_out_valid;
         sect_data <= fifo_out;
         if (fifo_out_valid) begin
            sect_last <= (fifo_cnt_r == 5'(asf_pkg::SECT_LEN - 1)); // R18
            fifo_cnt_r <= (fifo_cnt_r == 5'(asf_pkg::SECT_LEN - 1)) ? 5'd0 : fifo_cnt_r + 5'd1;
         end else begin
            sect_last <= 1'b0;
         end
      end
   end
endmodule : asf_framer

/* test/asf_framer_properties.sv */
`timescale 1ns/100ps
module asf_framer_properties (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] sect_data,
   input wire logic sect_valid,
   input wire logic sect_last,
   input wire logic sect_ready
);
   // ************************************************************
   // byte position tracking
   // ************************************************************
   logic [4:0] idx_r;
   logic [4:0] seq_r;
   logic diag_r;
   wire take = sect_valid && sect_ready;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // position, sequence and type of the section in flight
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         idx_r <= 5'h00;
         seq_r <= 5'h01;
         diag_r <= 1'b0;
      end else if (take) begin
         idx_r <= sect_last ? 5'h00 : idx_r + 5'h01;
         if (sect_last) seq_r <= seq_r + 5'h01; // five bits: 32 is code 0
         if (idx_r == 5'h01) diag_r <= sect_data[0];
      end
   end
   property p_hold;
      sect_valid && !sect_ready |=> sect_valid && $stable(sect_data) && $stable(sect_last);
   endproperty
   a_hold: assert property (p_hold) else $error("byte changed while stalled");
   property p_len;
      take && sect_last |-> idx_r == 5'h13;
   endproperty
   a_len: assert property (p_len) else $error("last flag off byte 19");
   property p_b0;
      sect_valid && idx_r == 5'h00 |-> sect_data == 8'h14;
   endproperty
   a_b0: assert property (p_b0) else $error("length byte wrong");
   property p_b1;
      sect_valid && idx_r == 5'h01 |-> sect_data == 8'h81 || sect_data == 8'h82;
   endproperty
   a_b1: assert property (p_b1) else $error("type byte wrong");
   property p_b2;
      sect_valid && idx_r == 5'h02 |-> sect_data inside {[8'h01:8'h20]};
   endproperty
   a_b2: assert property (p_b2) else $error("slot out of range");
   property p_b3;
      sect_valid && idx_r == 5'h03 |-> !sect_data[2] && sect_data[1:0] != 2'h3;
   endproperty
   a_b3: assert property (p_b3) else $error("specifier byte wrong");
   property p_seq;
      sect_valid && idx_r == 5'h03 |-> sect_data[7:3] == seq_r;
   endproperty
   a_seq: assert property (p_seq) else $error("sequence number wrong");
   property p_b5;
      sect_valid && diag_r && idx_r == 5'h05 |-> sect_data[7:6] == 2'h0;
   endproperty
   a_b5: assert property (p_b5) else $error("class byte top bits set");
   property p_b6;
      sect_valid && diag_r && idx_r == 5'h06 |-> !sect_data[7];
   endproperty
   a_b6: assert property (p_b6) else $error("status byte bit 7 set");
   property p_b7;
      sect_valid && diag_r && idx_r == 5'h07 |-> (sect_data & 8'hBF) == 8'h00;
   endproperty
   a_b7: assert property (p_b7) else $error("reserved bits set");
endmodule : asf_framer_properties
bind asf_framer asf_framer_properties u_asf_framer_properties (.aclk, .aresetn, .sect_data, .sect_valid,
   .sect_last, .sect_ready);

/* test/asf_sink.sv */
`timescale 1ns/100ps
// ************************************************************
// section consumer on the far side
// ************************************************************
module asf_sink (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] sect_data,
   input wire logic sect_valid,
   input wire logic sect_last,
   input wire logic stall,
   output logic sect_ready,
   output logic [7:0] got [20],
   output int frames,
   output int bad_frames
);
   int idx;
   logic [2:0] ph;
   // ready also drops one cycle in eight, so stalls hit every byte position
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sect_ready <= 1'b0;
         idx <= 0;
         frames <= 0;
         bad_frames <= 0;
         ph <= 3'h0;
      end else begin
         ph <= ph + 3'h1;
         sect_ready <= !stall && ph != 3'h5;
         if (sect_valid && sect_ready) begin
            got[idx % 20] <= sect_data;
            idx <= sect_last ? 0 : idx + 1;
            if (sect_last) frames <= frames + 1;
            if (sect_last != (idx == 19)) bad_frames <= bad_frames + 1;
         end
      end
   end
endmodule : asf_sink

/* test/asf_framer_test.sv */
`timescale 1ns/100ps
module asf_framer_test;
   localparam logic [63:0] GRP = 64'h8877_6655_4433_2211;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   // response ready held high, so back-to-back calls never toggle it in one step
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1, s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b1, stall = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [7:0] sect_data;
   logic sect_valid, sect_last, sect_ready;
   logic [7:0] got [20];
   int frames, bad_frames, n_errors = 0, checks_done = 0;
   logic [4:0] exp_seq = 5'h01;
   logic [3:0] cls [4] = '{4'hF, 4'h5, 4'h8, 4'hC};
   logic [7:0] cht [6] = '{8'h70, 8'h71, 8'h72, 8'h73, 8'h74, 8'h76};
   asf_framer u_asf_framer (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sect_data,
      .sect_valid, .sect_last, .sect_ready);
   asf_sink u_asf_sink (.aclk, .aresetn, .sect_data, .sect_valid, .sect_last, .stall, .sect_ready, .got,
      .frames, .bad_frames);
   // free-running 100 MHz clock
   always #5 aclk = ~aclk;
   // ************************************************************
   // shared tasks
   // ************************************************************
   task automatic print_verdict();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : print_verdict
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // bounded wait step; a hang ends the run as a failure
   task automatic tick(inout int n);
      @(posedge aclk);
      n++;
      if (n > 2000) begin
         n_errors++;
         print_verdict();
      end
   endtask : tick
   task automatic wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] resp);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         tick(n);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
   endtask : wr
   task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] resp);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         tick(n);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      resp = s_axi_rresp;
   endtask : rd
   // start a section and wait for its last byte; releases any stall after 40 cycles
   task automatic run(input logic [31:0] ctrl);
      int n;
      int f;
      logic [1:0] r;
      f = frames;
      wr(6'h00, ctrl, r);
      n = 0;
      while (frames == f) begin
         tick(n);
         if (n == 40) stall <= 1'b0;
      end
      exp_seq = exp_seq + 5'h01;
   endtask : run
   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic sect(input logic dg, input logic og, input logic [5:0] sl, input logic [31:0] rec,
      input logic [31:0] ch, input logic [7:0] en);
      logic [7:0] e [20];
      logic [1:0] r;
      e[0] = 8'h14;
      e[1] = dg ? 8'h81 : 8'h82;
      e[2] = {2'b00, sl};
      e[3] = {exp_seq, 1'b0, dg & og, dg & !og};
      e[4] = rec[7:0];
      e[5] = dg ? {2'b00, rec[13:8]} : rec[15:8];
      e[6] = dg ? {1'b0, rec[22:16]} : rec[23:16];
      e[7] = dg ? {1'b0, rec[30], 6'h00} : rec[31:24];
      for (int i = 0; i < 4; i++) e[8 + i] = ch[8 * i +: 8];
      for (int g = 0; g < 8; g++) e[12 + g] = (g == 0 || en[g]) ? GRP[8 * g +: 8] : 8'h00;
      wr(6'h04, {16'h0000, 2'b00, sl, 6'h00, og, dg}, r);
      wr(6'h08, rec, r);
      wr(6'h1C, rec, r);
      wr(6'h0C, ch, r);
      run({16'h0000, en, 8'h01});
      for (int i = 0; i < 4; i++) check("header", got[i], e[i]);
      for (int i = 4; i < 8; i++) check("record", got[i], e[i]);
      for (int i = 8; i < 20 && dg; i++) check("channel", got[i], e[i]);
      check("frame length", bad_frames, 0);
   endtask : sect
   task automatic t_regs();
      logic [31:0] d;
      logic [1:0] r;
      rd(6'h18, d, r);
      check("status reset", d, 32'h0000_0100);
      check("status resp", r, 2'h0);
      rd(6'h20, d, r);
      check("unmapped resp", r, 2'h2);
      check("unmapped data", d, 32'h0);
      wr(6'h18, 32'hFFFF_FFFF, r);
      check("status write resp", r, 2'h2);
      wr(6'h06, 32'h0, r);
      check("unaligned resp", r, 2'h2);
   endtask : t_regs
   // second start lands while the first section is still streaming
   task automatic t_busy();
      logic [31:0] d;
      logic [1:0] r;
      int f;
      f = frames;
      wr(6'h00, 32'h0000_0001, r);
      run(32'h0000_0001);
      repeat (40) @(posedge aclk);
      check("frames", frames - f, 1);
      rd(6'h18, d, r);
      check("dropped", d[31:24], 8'h01);
      check("issued", d[23:16], 8'h25);
   endtask : t_busy
   task automatic t_bad();
      logic [31:0] d;
      logic [1:0] r;
      int f;
      f = frames;
      for (int k = 0; k < 2; k++) begin
         wr(6'h04, k ? 32'h0000_2101 : 32'h0000_0001, r);
         wr(6'h00, 32'h0000_0001, r);
         repeat (40) @(posedge aclk);
         rd(6'h18, d, r);
         check("bad slot", d[13], 1'b1);
      end
      check("refused frames", frames - f, 0);
   endtask : t_bad
   // main sequence
   initial begin
      logic [1:0] r;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs();
      wr(6'h10, GRP[31:0], r);
      wr(6'h14, GRP[63:32], r);
      stall <= 1'b1;
      sect(1'b1, 1'b0, 6'h20, 32'hFFFF_FFFF, 32'h0408_1071, 8'hFE);
      sect(1'b1, 1'b1, 6'h01, 32'h0000_0000, 32'h0000_0070, 8'h00);
      for (int i = 0; i < 34; i++) begin
         sect(i % 4 != 3, i[1], 6'(i % 32 + 1), {8'(i * 37), 8'(i * 11), i[3:0], cls[i % 4], 8'(i * 5)},
            {8'(i), 8'h08, 8'h18, cht[i % 6]}, 8'(i * 29));
      end
      t_busy();
      t_bad();
      print_verdict();
   end
endmodule : asf_framer_test
